/* File: bench/art_testbench.sv */
// Self-checking register-level testbench of the auto-reload timer
`timescale 1ns/10ps
module testbench;
    import art_pkg::*;

    logic        clk;
    logic        srst;
    art_bus_t    bus;
    logic [7:0]  rdata;
    logic        ext_clk_pin;
    logic        lfo_pin;
    logic        suspend;
    logic        wake_req;
    logic        sync_pending;
    logic        irq_req;
    int          n_mismatch;
    int          total_checks;
    logic [7:0]  rd_val;
    logic        seen;
    logic [1:0]  xcodes [3];
    logic [7:0]  raddrs [9];

    art_timer dut_u
    (
        .clk          (clk),
        .srst         (srst),
        .bus          (bus),
        .rdata        (rdata),
        .ext_clk_pin  (ext_clk_pin),
        .lfo_pin      (lfo_pin),
        .suspend      (suspend),
        .wake_req     (wake_req),
        .sync_pending (sync_pending),
        .irq_req      (irq_req)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic finish_test;
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            $display("BAD %s expected %b seen %b", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        rd_val = rdata;
        chk8(name, exp, rd_val);
    endtask

    // Clock select held for exactly n edges, then back to no source
    task automatic run_sel(input logic [7:0] sel, input int n);
        wr(ADDR_CKSEL, sel);
        repeat (n - 2) @(posedge clk);
        wr(ADDR_CKSEL, 8'h00);
    endtask

    // Pin edges, each level held four cycles
    task automatic pins(input logic use_lfo, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (use_lfo)
                lfo_pin <= 1'b1;
            else
                ext_clk_pin <= 1'b1;
            repeat (4) @(posedge clk);
            lfo_pin <= 1'b0;
            ext_clk_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge clk);
        #1;
        chk1("irq_req", exp, irq_req);
    endtask

    initial
    begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        srst = 1'b1;
        bus = '0;
        ext_clk_pin = 1'b0;
        lfo_pin = 1'b0;
        suspend = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        xcodes = '{XSEL_DIV12, XSEL_EXT, XSEL_LFO};
        raddrs = '{ADDR_CKSEL, ADDR_CTRL, ADDR_RLL, ADDR_RLH, ADDR_CNTL, ADDR_CNTH, ADDR_STAT, ADDR_IEN, 8'h90};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (raddrs[i])
            rd_chk("reset value", raddrs[i], 8'h00);
        // 16-bit overflow with reload
        wr(ADDR_IEN, 8'h80);
        wr(ADDR_CTRL, 8'h06);
        wr(ADDR_RLL, 8'h34);
        wr(ADDR_RLH, 8'h12);
        wr(ADDR_CNTL, 8'hFE);
        wr(ADDR_CNTH, 8'hFF);
        run_sel(8'h40, 4);
        rd_chk("count low", ADDR_CNTL, 8'h36);
        rd_chk("count high", ADDR_CNTH, 8'h12);
        rd_chk("ctrl flags", ADDR_CTRL, 8'hC6);
        irq_chk(1'b1);
        wr(ADDR_CTRL, 8'h06);
        rd_chk("ctrl cleared", ADDR_CTRL, 8'h06);
        irq_chk(1'b0);
        // Low byte rollover only, carry into high byte
        wr(ADDR_CNTL, 8'hFE);
        wr(ADDR_CNTH, 8'h00);
        run_sel(8'h40, 2);
        rd_chk("carry high", ADDR_CNTH, 8'h01);
        rd_chk("low flag only", ADDR_CTRL, 8'h46);
        irq_chk(1'b0);
        wr(ADDR_CTRL, 8'h66);
        irq_chk(1'b1);
        // Run control off holds the 16-bit count
        wr(ADDR_CTRL, 8'h02);
        run_sel(8'h40, 6);
        rd_chk("held low", ADDR_CNTL, 8'h00);
        rd_chk("held high", ADDR_CNTH, 8'h01);
        // External select decode: 24 clocks of /12, 16 pin edges of /8
        foreach (xcodes[i])
        begin
            wr(ADDR_CNTL, 8'h00);
            wr(ADDR_CNTH, 8'h00);
            wr(ADDR_CTRL, {6'h01, xcodes[i]});
            if (xcodes[i] == XSEL_DIV12)
                repeat (22) @(posedge clk);
            else
            begin
                pins(xcodes[i] == XSEL_LFO, 16);
                repeat (20) @(posedge clk);
            end
            wr(ADDR_CTRL, 8'h06);
            rd_chk("source count", ADDR_CNTL, 8'h02);
        end
        // Split mode, high byte stopped
        wr(ADDR_CTRL, 8'h0A);
        wr(ADDR_RLL, 8'h10);
        wr(ADDR_RLH, 8'h20);
        wr(ADDR_CNTL, 8'hFE);
        wr(ADDR_CNTH, 8'hFE);
        run_sel(8'hC0, 3);
        rd_chk("split low", ADDR_CNTL, 8'h11);
        rd_chk("split high stopped", ADDR_CNTH, 8'hFE);
        rd_chk("split low flag", ADDR_CTRL, 8'h4A);
        irq_chk(1'b0);
        // Split mode, high byte running on its own select
        wr(ADDR_CTRL, 8'h0E);
        wr(ADDR_CNTL, 8'hFE);
        wr(ADDR_CNTH, 8'hFF);
        run_sel(8'h80, 2);
        rd_chk("split high", ADDR_CNTH, 8'h21);
        rd_chk("split low idle", ADDR_CNTL, 8'hFE);
        rd_chk("split high flag", ADDR_CTRL, 8'h8E);
        irq_chk(1'b1);
        // Overflow in suspend wakes the device
        wr(ADDR_CTRL, 8'h06);
        wr(ADDR_CNTL, 8'hFD);
        wr(ADDR_CNTH, 8'hFF);
        @(posedge clk);
        suspend <= 1'b1;
        wr(ADDR_CKSEL, 8'h40);
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge clk);
            #1;
            if (wake_req === 1'b1)
                seen = 1'b1;
        end
        chk1("wake_req", 1'b1, seen);
        wr(ADDR_CKSEL, 8'h00);
        @(posedge clk);
        suspend <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk1("sync after timer wake", 1'b0, sync_pending);
        // Wake by another source with no ticks running
        wr(ADDR_CTRL, 8'h06);
        @(posedge clk);
        suspend <= 1'b1;
        repeat (4) @(posedge clk);
        suspend <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1("sync pending", 1'b1, sync_pending);
        repeat (10) @(posedge clk);
        rd_chk("status", ADDR_STAT, 8'h01);
        wr(ADDR_CKSEL, 8'h40);
        repeat (5) @(posedge clk);
        #1;
        chk1("sync released", 1'b0, sync_pending);
        wr(ADDR_CKSEL, 8'h00);
        // Oscillator capture of a stopped count
        wr(ADDR_CNTL, 8'hCD);
        wr(ADDR_CNTH, 8'hAB);
        wr(ADDR_CTRL, 8'h16);
        pins(1'b1, 1);
        repeat (8) @(posedge clk);
        rd_chk("capture low", ADDR_RLL, 8'hCD);
        rd_chk("capture high", ADDR_RLH, 8'hAB);
        rd_chk("capture flag", ADDR_CTRL, 8'h96);
        irq_chk(1'b1);
        finish_test();
    end
endmodule

/* File: design/art_clk_div.sv */
// Pin synchroniser with falling-edge pulse and divide-by-N output
`timescale 1ns/10ps
module art_clk_div
#(
    parameter int DIV = art_pkg::DIV_EXT
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Asynchronous source pin
    input  wire logic src_pin,
    // Results
    output logic      fall_pulse,
    output logic      div_pulse,
    output logic      div_level
);
    import art_pkg::*;

    art_div_st_t state_ff;
    art_div_st_t nxt_state;

    always_comb
    begin
        nxt_state       = state_ff;
        nxt_state.sync  = {state_ff.sync[1:0], src_pin};
        nxt_state.fall  = state_ff.sync[2] & ~state_ff.sync[1];
        nxt_state.pulse = 1'b0;
        // Count rising edges of the synchronised pin
        if (state_ff.sync[1] & ~state_ff.sync[2])
        begin
            if (state_ff.cnt == 4'(DIV - 1))
            begin
                nxt_state.cnt   = 4'h0;
                nxt_state.pulse = 1'b1;
            end
            else
            begin
                nxt_state.cnt = state_ff.cnt + 4'h1;
            end
        end
        nxt_state.lvl = (nxt_state.cnt >= 4'(DIV / 2));
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign fall_pulse = state_ff.fall;
    assign div_pulse  = state_ff.pulse;
    assign div_level  = state_ff.lvl;

endmodule

/* File: design/art_pkg.sv */
// Register map, encodings and state types of the auto-reload timer
package art_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CKSEL = 8'h8E;
    localparam logic [7:0] ADDR_CTRL  = 8'h91;
    localparam logic [7:0] ADDR_RLL   = 8'h92;
    localparam logic [7:0] ADDR_RLH   = 8'h93;
    localparam logic [7:0] ADDR_CNTL  = 8'h94;
    localparam logic [7:0] ADDR_CNTH  = 8'h95;
    localparam logic [7:0] ADDR_STAT  = 8'h96;
    localparam logic [7:0] ADDR_IEN   = 8'hE6;

    // Control register fields
    localparam int CTRL_TFH   = 7;
    localparam int CTRL_TFL   = 6;
    localparam int CTRL_LEN   = 5;
    localparam int CTRL_CEN   = 4;
    localparam int CTRL_SPLIT = 3;
    localparam int CTRL_RUN   = 2;
    localparam int CTRL_XSEL  = 0;

    // Clock select, interrupt enable and status fields
    localparam int CKSEL_HI  = 7;
    localparam int CKSEL_LO  = 6;
    localparam int IEN_TMR   = 7;
    localparam int STAT_SYNC = 0;

    // External clock select encodings
    localparam logic [1:0] XSEL_DIV12 = 2'h0;
    localparam logic [1:0] XSEL_EXT   = 2'h1;
    localparam logic [1:0] XSEL_LFO   = 2'h3;

    // Dividers and counts
    localparam int DIV_SYS   = 12;
    localparam int DIV_EXT   = 8;
    localparam int SYNC_CLKS = 3;

    localparam logic [7:0]  BYTE_MAX  = 8'hFF;
    localparam logic [15:0] WORD_MAX  = 16'hFFFF;
    localparam logic [7:0]  READ_ZERO = 8'h00;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } art_bus_t;

    // Pin divider state
    typedef struct packed {
        logic [2:0] sync;
        logic [3:0] cnt;
        logic       fall;
        logic       pulse;
        logic       lvl;
    } art_div_st_t;

    // Prescaler state
    typedef struct packed {
        logic [3:0] cnt;
        logic       pulse;
    } art_pre_st_t;

    // Timer state
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] rl;
        logic        tf_h;
        logic        tf_l;
        logic        low_len;
        logic        cap_en;
        logic        split;
        logic        run;
        logic [1:0]  xsel;
        logic        msel_h;
        logic        msel_l;
        logic        irq_en;
        logic [1:0]  ext_rs;
        logic [1:0]  lfo_rs;
        logic        sus_q;
        logic        timer_woke;
        logic        sync_pend;
        logic [1:0]  sync_cnt;
        logic        wake;
        logic        irq;
        logic [7:0]  rdata;
    } art_st_t;

endpackage

/* File: design/art_presc.sv */
// System clock prescaler producing a one-cycle enable
`timescale 1ns/10ps
module art_presc
#(
    parameter int DIV = art_pkg::DIV_SYS
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Enable out
    output logic      tick
);
    import art_pkg::*;

    art_pre_st_t state_ff;
    art_pre_st_t nxt_state;

    always_comb
    begin
        nxt_state       = state_ff;
        nxt_state.pulse = 1'b0;
        if (state_ff.cnt == 4'(DIV - 1))
        begin
            nxt_state.cnt   = 4'h0;
            nxt_state.pulse = 1'b1;
        end
        else
        begin
            nxt_state.cnt = state_ff.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign tick = state_ff.pulse;

endmodule

/* File: design/art_timer.sv */
// Auto-reload timer with split mode, suspend wake-up and oscillator capture
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps

// Overview of operation
// - Two 8-bit count bytes form a 16-bit counter; split bit picks two 8-bit counters.
// - Count clock: system clock, system clock /12, external /8 or oscillator /8.
// - External and oscillator /8 clocks resynchronised outside suspend; in suspend they drive the counter directly.
// - Counter keeps running in suspend; its overflow wakes the device.
// - Wake by another source holds sync pending high until the third low-byte timer clock after wake.
// - 16-bit overflow from all ones loads the reload value and sets the high flag.
// - 16-bit mode with timer interrupts enabled interrupts on every overflow.
// - Low-byte interrupt enable adds an interrupt on each low byte rollover.
// - Split mode: each byte reloads from its own reload byte on overflow.
// - Split mode: run control gates only the high byte; low byte runs freely.
// - Per-byte select 1 means system clock; else two-bit external select decodes.
// - Split mode: high byte rollover sets high flag, low byte rollover low flag.
// - Split mode interrupts on high overflow, and low overflow when low enable set.
// - Hardware never clears the overflow flags; software clears and inspects both.
// - Capture: oscillator falling edge copies count to reload and sets high flag.
// - Low flag sets on every low byte rollover in every mode.
// - 16-bit mode counts only while run control is 1.
module art_timer
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Register port
    input  wire art_pkg::art_bus_t bus,
    output logic [7:0]            rdata,
    // Clock pins
    input  wire logic             ext_clk_pin,
    input  wire logic             lfo_pin,
    // Power management
    input  wire logic             suspend,
    output logic                  wake_req,
    output logic                  sync_pending,
    // Interrupt request
    output logic                  irq_req
);
    import art_pkg::*;

    art_st_t state_ff;
    art_st_t nxt_state;

    logic tick_div12;
    logic ext_pulse;
    logic ext_level;
    logic lfo_pulse;
    logic lfo_level;
    logic lfo_fall;
    logic ext_tick;
    logic lfo_tick;
    logic tick_l;
    logic tick_h;
    logic cap_hit;
    logic wr_cnt;

    // Clock source decode shared by both bytes
    function automatic logic pick_tick(input logic msel, input logic [1:0] xsel,
                                       input logic d12, input logic ext, input logic low_freq_osc);
        logic t;
        t = 1'b0;
        if (msel)
            t = 1'b1;
        else
        begin
            case (xsel)
                XSEL_DIV12: t = d12;
                XSEL_EXT:   t = ext;
                XSEL_LFO:   t = low_freq_osc;
                default:    t = 1'b0;
            endcase
        end
        return t;
    endfunction

    art_presc #(
        .DIV (DIV_SYS)
    ) u_presc (
        .clk  (clk),
        .srst (srst),
        .tick (tick_div12)
    );

    art_clk_div #(
        .DIV (DIV_EXT)
    ) u_ext_div (
        .clk        (clk),
        .srst       (srst),
        .src_pin    (ext_clk_pin),
        .fall_pulse (),
        .div_pulse  (ext_pulse),
        .div_level  (ext_level)
    );

    art_clk_div #(
        .DIV (DIV_EXT)
    ) u_lfo_div (
        .clk        (clk),
        .srst       (srst),
        .src_pin    (lfo_pin),
        .fall_pulse (lfo_fall),
        .div_pulse  (lfo_pulse),
        .div_level  (lfo_level)
    );

    // Suspend bypasses the resync stage
    assign ext_tick = suspend ? ext_pulse : (state_ff.ext_rs[0] & ~state_ff.ext_rs[1]);
    assign lfo_tick = suspend ? lfo_pulse : (state_ff.lfo_rs[0] & ~state_ff.lfo_rs[1]);
    assign tick_l   = pick_tick(state_ff.msel_l, state_ff.xsel, tick_div12, ext_tick, lfo_tick);
    assign tick_h   = pick_tick(state_ff.msel_h, state_ff.xsel, tick_div12, ext_tick, lfo_tick);
    assign cap_hit  = state_ff.cap_en & lfo_fall;
    assign wr_cnt   = bus.wr & ((bus.addr == ADDR_CNTL) | (bus.addr == ADDR_CNTH));

    always_comb
    begin
        logic set_l;
        logic set_h;
        logic lo_wrap;
        logic hi_wrap;
        set_l     = 1'b0;
        set_h     = 1'b0;
        lo_wrap   = (state_ff.cnt[7:0] == BYTE_MAX);
        hi_wrap   = (state_ff.cnt[15:8] == BYTE_MAX);
        nxt_state = state_ff;

        nxt_state.ext_rs = {state_ff.ext_rs[0], ext_level};
        nxt_state.lfo_rs = {state_ff.lfo_rs[0], lfo_level};

        // Counting
        if (!state_ff.split)
        begin
            if (tick_l && state_ff.run)
            begin
                if (state_ff.cnt == WORD_MAX)
                begin
                    nxt_state.cnt = state_ff.rl;
                    set_h         = 1'b1;
                end
                else
                begin
                    nxt_state.cnt = state_ff.cnt + 16'h0001;
                end
                set_l = lo_wrap;
            end
        end
        else
        begin
            if (tick_l)
            begin
                nxt_state.cnt[7:0] = lo_wrap ? state_ff.rl[7:0] : state_ff.cnt[7:0] + 8'h01;
                set_l              = lo_wrap;
            end
            if (tick_h && state_ff.run)
            begin
                nxt_state.cnt[15:8] = hi_wrap ? state_ff.rl[15:8] : state_ff.cnt[15:8] + 8'h01;
                set_h               = hi_wrap;
            end
        end

        // Register writes
        if (bus.wr)
        begin
            if (bus.addr == ADDR_CTRL)
            begin
                nxt_state.tf_h    = bus.wdata[CTRL_TFH];
                nxt_state.tf_l    = bus.wdata[CTRL_TFL];
                nxt_state.low_len = bus.wdata[CTRL_LEN];
                nxt_state.cap_en  = bus.wdata[CTRL_CEN];
                nxt_state.split   = bus.wdata[CTRL_SPLIT];
                nxt_state.run     = bus.wdata[CTRL_RUN];
                nxt_state.xsel    = bus.wdata[CTRL_XSEL +: 2];
            end
            else if (bus.addr == ADDR_RLL)
                nxt_state.rl[7:0] = bus.wdata;
            else if (bus.addr == ADDR_RLH)
                nxt_state.rl[15:8] = bus.wdata;
            else if (bus.addr == ADDR_CNTL)
                nxt_state.cnt[7:0] = bus.wdata;
            else if (bus.addr == ADDR_CNTH)
                nxt_state.cnt[15:8] = bus.wdata;
            else if (bus.addr == ADDR_CKSEL)
            begin
                nxt_state.msel_h = bus.wdata[CKSEL_HI];
                nxt_state.msel_l = bus.wdata[CKSEL_LO];
            end
            else if (bus.addr == ADDR_IEN)
                nxt_state.irq_en = bus.wdata[IEN_TMR];
        end

        // Hardware events win over a clearing write
        if (cap_hit)
            nxt_state.rl = state_ff.cnt;
        nxt_state.tf_h = nxt_state.tf_h | set_h | cap_hit;
        nxt_state.tf_l = nxt_state.tf_l | set_l;
        nxt_state.irq  = state_ff.irq_en & (nxt_state.tf_h | (state_ff.low_len & nxt_state.tf_l));

        // Wake-up and sync tracking
        nxt_state.sus_q = suspend;
        nxt_state.wake  = suspend & set_h;
        if (suspend && set_h)
            nxt_state.timer_woke = 1'b1;
        else if (!suspend)
            nxt_state.timer_woke = 1'b0;
        if (state_ff.sus_q && !suspend && !state_ff.timer_woke)
        begin
            nxt_state.sync_pend = 1'b1;
            nxt_state.sync_cnt  = 2'h0;
        end
        else if (state_ff.sync_pend && tick_l)
        begin
            if (state_ff.sync_cnt == 2'(SYNC_CLKS - 1))
                nxt_state.sync_pend = 1'b0;
            else
                nxt_state.sync_cnt = state_ff.sync_cnt + 2'h1;
        end

        // Register reads
        nxt_state.rdata = READ_ZERO;
        if (bus.rd)
        begin
            if (bus.addr == ADDR_CTRL)
                nxt_state.rdata = {state_ff.tf_h, state_ff.tf_l, state_ff.low_len, state_ff.cap_en,
                                   state_ff.split, state_ff.run, state_ff.xsel};
            else if (bus.addr == ADDR_RLL)
                nxt_state.rdata = state_ff.rl[7:0];
            else if (bus.addr == ADDR_RLH)
                nxt_state.rdata = state_ff.rl[15:8];
            else if (bus.addr == ADDR_CNTL)
                nxt_state.rdata = state_ff.cnt[7:0];
            else if (bus.addr == ADDR_CNTH)
                nxt_state.rdata = state_ff.cnt[15:8];
            else if (bus.addr == ADDR_CKSEL)
            begin
                nxt_state.rdata[CKSEL_HI] = state_ff.msel_h;
                nxt_state.rdata[CKSEL_LO] = state_ff.msel_l;
            end
            else if (bus.addr == ADDR_IEN)
                nxt_state.rdata[IEN_TMR] = state_ff.irq_en;
            else if (bus.addr == ADDR_STAT)
                nxt_state.rdata[STAT_SYNC] = state_ff.sync_pend;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign rdata        = state_ff.rdata;
    assign wake_req     = state_ff.wake;
    assign sync_pending = state_ff.sync_pend;
    assign irq_req      = state_ff.irq;

    // Checks
    a_wrap_reload_16: assert property (
        @(posedge clk) disable iff (srst)
        !state_ff.split && state_ff.run && tick_l && state_ff.cnt == WORD_MAX && !wr_cnt && !cap_hit
        |=> state_ff.cnt == $past(state_ff.rl) && state_ff.tf_h)
        else $error("16-bit overflow did not reload or flag");

    a_run_gates_16: assert property (
        @(posedge clk) disable iff (srst)
        !state_ff.split && !state_ff.run && !wr_cnt |=> $stable(state_ff.cnt))
        else $error("16-bit counter moved while stopped");

    a_low_byte_free: assert property (
        @(posedge clk) disable iff (srst)
        state_ff.split && tick_l && !state_ff.run && !wr_cnt && state_ff.cnt[7:0] != BYTE_MAX
        |=> state_ff.cnt[7:0] == $past(state_ff.cnt[7:0]) + 8'h01 && $stable(state_ff.cnt[15:8]))
        else $error("split low byte not free running");

    a_split_low_reload: assert property (
        @(posedge clk) disable iff (srst)
        state_ff.split && tick_l && !wr_cnt && state_ff.cnt[7:0] == BYTE_MAX
        |=> state_ff.cnt[7:0] == $past(state_ff.rl[7:0]))
        else $error("split low byte reload wrong");

    a_low_flag_set: assert property (
        @(posedge clk) disable iff (srst)
        tick_l && (state_ff.split || state_ff.run) && state_ff.cnt[7:0] == BYTE_MAX |=> state_ff.tf_l)
        else $error("low rollover did not set low flag");

    a_flag_sticky: assert property (
        @(posedge clk) disable iff (srst)
        state_ff.tf_h && !(bus.wr && bus.addr == ADDR_CTRL) |=> state_ff.tf_h)
        else $error("high flag cleared without a write");

    a_capture_copy: assert property (
        @(posedge clk) disable iff (srst)
        cap_hit |=> state_ff.rl == $past(state_ff.cnt) && state_ff.tf_h)
        else $error("capture did not copy count");

    a_irq_high_flag: assert property (
        @(posedge clk) disable iff (srst)
        $rose(state_ff.tf_h) && state_ff.irq_en && $stable(state_ff.irq_en) |-> irq_req)
        else $error("high flag raised without interrupt");

    a_irq_low_gate: assert property (
        @(posedge clk) disable iff (srst)
        !$past(state_ff.low_len) && !state_ff.tf_h |-> !irq_req)
        else $error("low flag interrupted while disabled");

    a_wake_on_ovf: assert property (
        @(posedge clk) disable iff (srst)
        suspend && !state_ff.split && state_ff.run && tick_l && state_ff.cnt == WORD_MAX |=> wake_req)
        else $error("overflow in suspend did not wake");

    a_sync_pend_set: assert property (
        @(posedge clk) disable iff (srst)
        $fell(suspend) && !state_ff.timer_woke ##1 1'b1 |-> sync_pending)
        else $error("foreign wake did not raise sync pending");

    a_sys_clock_sel: assert property (
        @(posedge clk) disable iff (srst)
        state_ff.msel_l && !state_ff.split && state_ff.run && !wr_cnt && state_ff.cnt[7:0] != BYTE_MAX
        |=> state_ff.cnt[7:0] == $past(state_ff.cnt[7:0]) + 8'h01)
        else $error("system clock select did not count");

    a_high_sel_sys: assert property (
        @(posedge clk) disable iff (srst)
        state_ff.split && state_ff.msel_h && state_ff.run && !wr_cnt && state_ff.cnt[15:8] != BYTE_MAX
        |=> state_ff.cnt[15:8] == $past(state_ff.cnt[15:8]) + 8'h01)
        else $error("split high byte did not count on system clock");

    a_split_high_reload: assert property (
        @(posedge clk) disable iff (srst)
        state_ff.split && state_ff.run && tick_h && !wr_cnt && state_ff.cnt[15:8] == BYTE_MAX
        |=> state_ff.cnt[15:8] == $past(state_ff.rl[15:8]) && state_ff.tf_h)
        else $error("split high byte reload or flag wrong");

    a_carry_into_high: assert property (
        @(posedge clk) disable iff (srst)
        !state_ff.split && state_ff.run && tick_l && !wr_cnt && state_ff.cnt[7:0] == BYTE_MAX
        && state_ff.cnt[15:8] != BYTE_MAX |=> state_ff.cnt[15:8] == $past(state_ff.cnt[15:8]) + 8'h01)
        else $error("low byte rollover did not carry");

    a_low_irq_path: assert property (
        @(posedge clk) disable iff (srst)
        $past(state_ff.irq_en) && $past(state_ff.low_len) && state_ff.tf_l |-> irq_req)
        else $error("low flag did not interrupt while enabled");

    a_sync_pend_clear: assert property (
        @(posedge clk) disable iff (srst)
        state_ff.sync_pend && tick_l && state_ff.sync_cnt == 2'(SYNC_CLKS - 1) && !(state_ff.sus_q && !suspend)
        |=> !sync_pending)
        else $error("sync pending held past its third tick");

endmodule
